// File: rtl/manchester_tx_control.v
`timescale 1ns/1ps
`include "coder_defs.vh"
// Function
// - Control register: enable, order, format, idle level
// - Base clock divides peripheral clock by 2^n
// - Divisor below four behaves as four
// - Bit period is twice divisor periods
// - Status read-only, low bits read zero
// - Status clears on reset or disable
// - Busy flag set while transmitting
// - Busy stays high across back-to-back words
// - Buffer write while enabled starts transmission
// - Bit count field sends count plus one

// ==========================================
// Word queue
module byte_fifo #(
	parameter WIDTH = 11,
	parameter DEPTH = 8,
	parameter AW = 3
) (
	input wire clock_i,
	input wire nrst_i,
	input wire en_i,
	input wire flush_i,
	input wire in_valid_i,
	output wire in_ready_o,
	input wire [WIDTH-1:0] in_data_i,
	output wire out_valid_o,
	input wire out_ready_i,
	output wire [WIDTH-1:0] out_data_o
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wr_q;
	reg [AW-1:0] rd_q;
	reg [AW:0] cnt_q;
	wire push;
	wire pop;
	assign in_ready_o = (cnt_q != DEPTH);
	assign out_valid_o = (cnt_q != {(AW+1){1'b0}});
	assign out_data_o = mem[rd_q];
	assign push = in_valid_i & in_ready_o;
	assign pop = out_valid_o & out_ready_i;
	always @(posedge clock_i) begin
		if (en_i && push) begin
			mem[wr_q] <= in_data_i;
		end
	end
	always @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			wr_q <= {AW{1'b0}};
			rd_q <= {AW{1'b0}};
			cnt_q <= {(AW+1){1'b0}};
		end else if (en_i) begin
			// Flush wins over push, so a disable never leaves a stale word
			if (flush_i) begin
				wr_q <= {AW{1'b0}};
				rd_q <= {AW{1'b0}};
				cnt_q <= {(AW+1){1'b0}};
			end else begin
				if (push) begin
					wr_q <= wr_q + 1'b1;
				end
				if (pop) begin
					rd_q <= rd_q + 1'b1;
				end
				cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
			end
		end
	end
endmodule

// ==========================================
// Control, clocking and status
module manchester_tx_control (
	input wire clock_i,
	input wire nrst_i,
	input wire clk_en_i,
	input wire [15:0] addr_i,
	input wire wr_i,
	input wire rd_i,
	input wire [7:0] wdata_i,
	output reg [7:0] rdata_o,
	output reg serial_code_output_o,
	output reg serial_code_oe_n_o,
	output reg write_full_o
);
	localparam ST_IDLE = 3'b001;
	localparam ST_FIRST = 3'b010;
	localparam ST_SECOND = 3'b100;
	reg [7:0] coder_control_q;
	reg [2:0] base_sel_q;
	reg [4:0] baud_div_q;
	reg [2:0] bit_count_q;
	reg [7:0] tx_buffer_q;
	reg busy_q;
	reg [2:0] state_q;
	reg [4:0] pre_q;
	reg [4:0] kcnt_q;
	reg [7:0] shift_q;
	reg [2:0] left_q;
	reg line_d;
	reg [7:0] rd_d;
	wire enable;
	wire tx_write;
	wire fifo_ready;
	wire fifo_valid;
	wire [10:0] fifo_data;
	wire load;
	wire base_tick;
	wire half_tick;
	wire [4:0] k_eff;
	wire out_bit;
	wire wr_control;
	wire wr_base_clock;
	wire wr_baud_div;
	wire wr_bit_count;
	wire wr_tx_buffer;
	// ==========================================
	// Register access
	function hit;
		input [15:0] a;
		input [15:0] b;
		begin
			hit = (a == b);
		end
	endfunction
	assign enable = coder_control_q[`CTL_ENABLE_BIT];
	assign wr_control = wr_i & hit(addr_i, `ADDR_CONTROL);
	assign wr_base_clock = wr_i & hit(addr_i, `ADDR_BASE_CLOCK);
	assign wr_baud_div = wr_i & hit(addr_i, `ADDR_BAUD_DIV);
	assign wr_bit_count = wr_i & hit(addr_i, `ADDR_BIT_COUNT);
	assign wr_tx_buffer = wr_i & hit(addr_i, `ADDR_TX_BUFFER);
	assign tx_write = wr_tx_buffer & enable;
	always @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			coder_control_q <= `RST_CONTROL;
			base_sel_q <= `RST_BASE_CLOCK;
			baud_div_q <= `RST_BAUD_DIV;
			bit_count_q <= `RST_BIT_COUNT;
			tx_buffer_q <= `RST_TX_BUFFER;
			rdata_o <= 8'h00;
		end else if (clk_en_i) begin
			// Unused control bits stay zero so reads match the layout
			if (wr_control) begin
				coder_control_q <= wdata_i & 8'h93;
			end
			if (wr_base_clock) begin
				base_sel_q <= wdata_i[2:0];
			end
			if (wr_baud_div) begin
				baud_div_q <= wdata_i[4:0];
			end
			if (wr_bit_count) begin
				bit_count_q <= wdata_i[2:0];
			end
			if (wr_tx_buffer) begin
				tx_buffer_q <= wdata_i;
			end
			if (rd_i) begin
				rdata_o <= rd_d;
			end
		end
	end
	// Status writes have no decode at all, so they are dropped
	always @* begin
		rd_d = 8'h00;
		case (addr_i)
			`ADDR_CONTROL: rd_d = coder_control_q;
			`ADDR_BASE_CLOCK: rd_d = {5'h00, base_sel_q};
			`ADDR_BAUD_DIV: rd_d = {3'h0, baud_div_q};
			`ADDR_BIT_COUNT: rd_d = {5'h00, bit_count_q};
			`ADDR_TX_BUFFER: rd_d = tx_buffer_q;
			// Gated by enable so a read just after a disable already shows zero
			`ADDR_STATUS: rd_d = {busy_q & enable, 7'h00};
			default: rd_d = 8'h00;
		endcase
	end
	// ==========================================
	// Queue of pending words: data, bit count
	byte_fifo #(.WIDTH(11), .DEPTH(`FIFO_DEPTH), .AW(`FIFO_AW)) u_fifo (
		.clock_i(clock_i),
		.nrst_i(nrst_i),
		.en_i(clk_en_i),
		.flush_i(~enable),
		.in_valid_i(tx_write),
		.in_ready_o(fifo_ready),
		.in_data_i({bit_count_q, wdata_i}),
		.out_valid_o(fifo_valid),
		.out_ready_i(load),
		.out_data_o(fifo_data)
	);
	// ==========================================
	// Baud generation
	// Codes 6 and 7 are prohibited; the prescaler then simply wraps at 32
	assign base_tick = (pre_q == ((5'h01 << base_sel_q) - 5'h01));
	assign k_eff = (baud_div_q < `MIN_DIVISOR) ? `MIN_DIVISOR : baud_div_q;
	// Two k periods per bit: one per half
	assign half_tick = base_tick && (kcnt_q == k_eff - 5'h01);
	assign load = fifo_valid && ((state_q == ST_IDLE) || (state_q == ST_SECOND && half_tick && left_q == 3'h0));
	// Short words send the low bits, so MSB-first starts at bit count
	assign out_bit = coder_control_q[`CTL_ORDER_BIT] ? shift_q[0] : shift_q[7];
	// ==========================================
	// Word alignment in the shift register
	function [7:0] first_aligned;
		input [7:0] data;
		input [2:0] last;
		input lsb_first;
		begin
			first_aligned = lsb_first ? data : (data << (3'h7 - last));
		end
	endfunction
	function [7:0] next_word;
		input [7:0] word;
		input lsb_first;
		begin
			next_word = lsb_first ? (word >> 1) : (word << 1);
		end
	endfunction
	// ==========================================
	// Line output
	always @* begin
		line_d = coder_control_q[`CTL_IDLE_BIT];
		if (enable && state_q != ST_IDLE) begin
			if (coder_control_q[`CTL_FORMAT_BIT]) begin
				line_d = out_bit;
			end else begin
				line_d = (state_q == ST_FIRST) ? out_bit : ~out_bit;
			end
		end
	end
	// ==========================================
	// Serialiser state
	always @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			pre_q <= 5'h00;
			kcnt_q <= 5'h00;
			state_q <= ST_IDLE;
			shift_q <= 8'h00;
			left_q <= 3'h0;
			busy_q <= 1'b0;
			serial_code_output_o <= 1'b0;
			serial_code_oe_n_o <= 1'b1;
			write_full_o <= 1'b0;
		end else if (clk_en_i) begin
			write_full_o <= ~fifo_ready;
			serial_code_oe_n_o <= ~enable;
			if (!enable) begin
				state_q <= ST_IDLE;
				busy_q <= 1'b0;
				pre_q <= 5'h00;
				kcnt_q <= 5'h00;
			end else begin
				pre_q <= base_tick ? 5'h00 : pre_q + 5'h01;
				if (state_q == ST_IDLE) begin
					kcnt_q <= 5'h00;
					pre_q <= 5'h00;
				end else if (base_tick) begin
					kcnt_q <= half_tick ? 5'h00 : kcnt_q + 5'h01;
				end
				if (load) begin
					state_q <= ST_FIRST;
					busy_q <= 1'b1;
					left_q <= fifo_data[10:8];
					shift_q <= first_aligned(fifo_data[7:0], fifo_data[10:8], coder_control_q[`CTL_ORDER_BIT]);
				end else begin
					case (state_q)
						ST_IDLE: begin
							busy_q <= 1'b0;
						end
						ST_FIRST: begin
							if (half_tick) begin
								state_q <= ST_SECOND;
							end
						end
						ST_SECOND: begin
							if (half_tick) begin
								if (left_q == 3'h0) begin
									state_q <= ST_IDLE;
									busy_q <= 1'b0;
								end else begin
									state_q <= ST_FIRST;
									left_q <= left_q - 3'h1;
									shift_q <= next_word(shift_q, coder_control_q[`CTL_ORDER_BIT]);
								end
							end
						end
						default: begin
							state_q <= ST_IDLE;
						end
					endcase
				end
			end
			// Output follows the state a cycle later; the lag is uniform per half
			serial_code_output_o <= line_d;
		end
	end
endmodule

// File: pkg/coder_defs.vh
`ifndef CODER_DEFS_VH
`define CODER_DEFS_VH
// ==========================================
// Register addresses
`define ADDR_TX_BUFFER 16'hFF4A
`define ADDR_BIT_COUNT 16'hFF4B
`define ADDR_CONTROL 16'hFF4C
`define ADDR_BASE_CLOCK 16'hFF4D
`define ADDR_BAUD_DIV 16'hFF4E
`define ADDR_STATUS 16'hFF47
// ==========================================
// Field positions
`define CTL_ENABLE_BIT 7
`define CTL_ORDER_BIT 4
`define CTL_FORMAT_BIT 1
`define CTL_IDLE_BIT 0
`define STS_BUSY_BIT 7
// ==========================================
// Reset values
`define RST_CONTROL 8'h10
`define RST_BASE_CLOCK 3'h0
`define RST_BAUD_DIV 5'h1F
`define RST_BIT_COUNT 3'h7
`define RST_TX_BUFFER 8'hFF
`define MIN_DIVISOR 5'h04
`define FIFO_DEPTH 8
`define FIFO_AW 3
`endif

// File: tb/mtx_sva.sv
`timescale 1ns/1ps
module mtx_sva (
	input wire clock_i,
	input wire nrst_i,
	input wire clk_en_i,
	input wire [15:0] addr_i,
	input wire wr_i,
	input wire rd_i,
	input wire [7:0] wdata_i,
	input wire [7:0] rdata_o,
	input wire serial_code_output_o,
	input wire serial_code_oe_n_o,
	input wire write_full_o
);
	reg en_q;
	default clocking @(posedge clock_i); endclocking
	default disable iff (!nrst_i || !clk_en_i);
	// ==========
	// Shadow of the enable bit
	always @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i)
			en_q <= 1'h0;
		else if (clk_en_i && wr_i && addr_i == 16'hFF4C)
			en_q <= wdata_i[7];
	end
	AST_STS_LOW: assert property (rd_i && addr_i == 16'hFF47 |=> rdata_o[6:0] == 7'h00) else $error("sts");
	AST_CTL_RSV: assert property (rd_i && addr_i == 16'hFF4C |=> rdata_o[6:5] == 2'h0 && rdata_o[3:2] == 2'h0) else $error("ctl");
	AST_BASE_RSV: assert property (rd_i && addr_i == 16'hFF4D |=> rdata_o[7:3] == 5'h00) else $error("base");
	AST_BAUD_RSV: assert property (rd_i && addr_i == 16'hFF4E |=> rdata_o[7:5] == 3'h0) else $error("baud");
	AST_OE_ON: assert property (wr_i && addr_i == 16'hFF4C && wdata_i[7] |-> ##2 !serial_code_oe_n_o) else $error("on");
	AST_OE_OFF: assert property (wr_i && addr_i == 16'hFF4C && !wdata_i[7] |-> ##2 serial_code_oe_n_o) else $error("off");
	AST_BUSY_SET: assert property (wr_i && addr_i == 16'hFF4A && en_q ##2 rd_i && addr_i == 16'hFF47 |=> rdata_o[7]) else $error("busy");
	AST_STS_CLR: assert property (rd_i && addr_i == 16'hFF47 && !en_q && !$past(en_q) |=> rdata_o == 8'h00) else $error("clr");
endmodule
bind manchester_tx_control mtx_sva mtx_sva_i (.clock_i(clock_i), .nrst_i(nrst_i), .clk_en_i(clk_en_i),
	.addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
	.serial_code_output_o(serial_code_output_o), .serial_code_oe_n_o(serial_code_oe_n_o), .write_full_o(write_full_o));

// File: tb/line_rx.sv
`timescale 1ns/1ps
module line_rx (
	input wire clock_i,
	input wire line_i
);
	// Mid-half sampling absorbs the one-cycle start uncertainty
	task automatic capture(input int h, input int n, output logic [31:0] v);
		v = 32'h0;
		repeat (2 + h / 2) @(posedge clock_i);
		for (int i = 0; i < n; i++) begin
			#1 v[i] = line_i;
			repeat (h) @(posedge clock_i);
		end
	endtask
endmodule

// File: tb/testbench.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin fails++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module testbench;
	reg clk = 1'h0, nrst = 1'h0, wr = 1'h0, rd = 1'h0, ce = 1'h1;
	reg [15:0] addr = 16'h0000, dw;
	reg [7:0] wdata = 8'h00, d;
	wire [7:0] rdata;
	wire line, full, oe;
	int fails = 0, samples_checked = 0, cyc = 0, m;
	manchester_tx_control manchester_tx_control_i (.clock_i(clk), .nrst_i(nrst), .clk_en_i(ce), .addr_i(addr),
		.wr_i(wr), .rd_i(rd), .wdata_i(wdata), .rdata_o(rdata), .serial_code_output_o(line),
		.serial_code_oe_n_o(oe), .write_full_o(full));
	line_rx line_rx_i (.clock_i(clk), .line_i(line));
	initial begin
		forever #4 clk = ~clk;
	end
	task automatic wreg(input [15:0] a, input [7:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr <= 1'h1;
		@(posedge clk);
		wr <= 1'h0;
	endtask
	task automatic rreg(input [15:0] a);
		@(posedge clk);
		addr <= a;
		rd <= 1'h1;
		@(posedge clk);
		rd <= 1'h0;
		@(posedge clk);
		#1 d = rdata;
	endtask
	task automatic end_of_test;
		$display("checked %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 60000) begin
			fails++;
			end_of_test;
		end
	end
	// ==========
	// One configured transfer of one or two words, checked half by half
	task automatic xfer(input [2:0] md);
		int sel, k, n, nw, i, b;
		logic [31:0] got, ex;
		logic [7:0] cfg;
		logic [7:0] word_q[$];
		sel = md % 6;
		k = md == 7 ? 31 : $urandom % 8;
		n = $urandom % 8 + 1;
		nw = $urandom % 2 + 1;
		dw = $urandom;
		cfg = {1'h1, 2'h0, md[0], 2'h0, md[1], md[2]};
		wreg(16'hFF4C, 8'h00);
		wreg(16'hFF4D, 8'(sel));
		wreg(16'hFF4E, 8'(k));
		wreg(16'hFF4B, 8'(n - 1));
		wreg(16'hFF4C, cfg);
		rreg(16'hFF4C);
		`CHK("control", cfg, d)
		`CHK("idle", cfg[0], line)
		`CHK("oe", 1'h0, oe)
		word_q.push_back(dw[7:0]);
		if (nw == 2)
			word_q.push_back(dw[15:8]);
		ex = 32'h0;
		for (i = 0; i < 2 * n * nw; i++) begin
			b = word_q[i / (2 * n)][cfg[4] ? i / 2 % n : n - 1 - i / 2 % n];
			ex[i] = cfg[1] ? b : b ^ (i % 2);
		end
		wreg(16'hFF4A, dw[7:0]);
		fork
			line_rx_i.capture((1 << sel) * (k < 4 ? 4 : k), 2 * n * nw, got);
			begin
				if (nw == 2)
					wreg(16'hFF4A, dw[15:8]);
				rreg(16'hFF47);
				`CHK("busy", 8'h80, d)
			end
		join
		`CHK("halves", ex, got)
		i = 0;
		do begin
			rreg(16'hFF47);
			i++;
		end while (d[7] && i < 50);
		`CHK("done", 8'h00, d)
		`CHK("idle after", cfg[0], line)
	endtask
	initial begin
		d = $urandom(32'h4D3B);
		repeat (8) @(posedge clk);
		nrst <= 1'h1;
		rreg(16'hFF4C);
		`CHK("ctl reset", 8'h10, d)
		rreg(16'hFF4D);
		`CHK("base reset", 8'h00, d)
		rreg(16'hFF4E);
		`CHK("baud reset", 8'h1F, d)
		rreg(16'hFF4B);
		`CHK("count reset", 8'h07, d)
		wreg(16'hFF47, 8'hFF);
		rreg(16'hFF47);
		`CHK("sts write", 8'h00, d)
		for (m = 0; m < 8; m++)
			xfer(3'(m));
		wreg(16'hFF4C, 8'h80);
		repeat (10) wreg(16'hFF4A, 8'hA5);
		`CHK("full", 1'h1, full)
		wreg(16'hFF4C, 8'h00);
		rreg(16'hFF47);
		`CHK("abort", 8'h00, d)
		`CHK("flushed", 1'h0, full)
		`CHK("oe off", 1'h1, oe)
		// Clock enable low must freeze the register file
		wreg(16'hFF4E, 8'h0A);
		@(posedge clk);
		ce <= 1'h0;
		wreg(16'hFF4E, 8'h05);
		@(posedge clk);
		ce <= 1'h1;
		rreg(16'hFF4E);
		`CHK("frozen", 8'h0A, d)
		// Reset in mid-transfer clears status and restores control
		wreg(16'hFF4C, 8'h80);
		wreg(16'hFF4A, 8'h3C);
		rreg(16'hFF47);
		`CHK("busy pre reset", 8'h80, d)
		@(posedge clk);
		nrst <= 1'h0;
		repeat (2) @(posedge clk);
		nrst <= 1'h1;
		rreg(16'hFF47);
		`CHK("sts reset", 8'h00, d)
		rreg(16'hFF4C);
		`CHK("ctl after reset", 8'h10, d)
		end_of_test;
	end
endmodule
